// file: src/lcr_top.sv
// lcr_top: panel controller register bank, display memory portal and event logic
//
// Strobed register access is this design's own decision.
module lcr_top
  import lcr_pkg::*;
#(
  parameter int BANK_BYTES = lcr_pkg::BANK_DEPTH
) (
  // clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RESETN,
  // register port
  input  wire logic [lcr_pkg::ADDR_W-1:0]    ADDR,
  input  wire logic [lcr_pkg::DATA_W-1:0]    WDATA,
  input  wire logic                          WR,
  input  wire logic                          RD,
  output logic      [lcr_pkg::DATA_W-1:0]    RDATA,
  // power and supply
  input  wire logic                          POWER_ENABLE,
  input  wire logic                          PUMP_SUPPLY,
  // frame timing from the waveform generator
  input  wire logic                          FRAME_END,
  input  wire logic                          BLINK_START,
  input  wire logic                          BANK_SWITCH_A_TO_B,
  // panel read of display memory
  input  wire logic                          DISP_BANK_B,
  input  wire logic [lcr_pkg::IDX_W-1:0]     DISP_INDEX,
  output logic      [lcr_pkg::DATA_W-1:0]    DISP_DATA,
  // controller state
  output logic                               RUNNING,
  output lcr_pkg::lcr_ctrl_t                 APPLIED_CFG,
  output lcr_pkg::lcr_contrast_t             CONTRAST,
  output logic                               LCD_IRQ
);

  import lcr_pkg::*;

  // ==========================================================
  // functions

  // true when the pointer names a byte of either bank
  function automatic logic ptr_valid(input logic [PTR_W-1:0] p);
    ptr_valid = (p[IDX_W-1:0] <= IDX_LAST);
  endfunction : ptr_valid

  // pointer after one portal access
  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p);
    if (p == BANK_A_LAST) begin
      ptr_step = BANK_A_FIRST;
    end else if (p == BANK_B_LAST) begin
      ptr_step = BANK_B_FIRST;
    end else begin
      ptr_step = p + 5'h01;
    end
  endfunction : ptr_step

  // ==========================================================
  // state
  logic [PTR_W-1:0]  ptr_reg;
  logic [PTR_W-1:0]  ptr_next;
  lcr_ctrl_t         pend_reg;
  lcr_ctrl_t         pend_next;
  lcr_ctrl_t         appl_reg;
  lcr_ctrl_t         appl_next;
  lcr_run_t          run_reg;
  lcr_run_t          run_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] disp_reg;
  logic [DATA_W-1:0] disp_next;
  logic              irq_reg;
  logic              irq_next;

  // ==========================================================
  // address decode
  wire sel_ptr    = (ADDR == OFF_SUBADDRESS_POINTER);
  wire sel_portal = (ADDR == OFF_SUBDATA_PORTAL);
  wire sel_clk    = (ADDR == OFF_PANEL_CLOCK_CONFIG);
  wire sel_ctl0   = (ADDR == OFF_PANEL_CONTROL_ZERO);
  wire sel_ctl1   = (ADDR == OFF_PANEL_CONTROL_ONE);
  wire sel_ctl2   = (ADDR == OFF_PANEL_CONTROL_TWO);
  wire sel_ctl3   = (ADDR == OFF_PANEL_CONTROL_THREE);

  wire portal_access = sel_portal && (WR || RD);
  wire ptr_ok        = ptr_valid(ptr_reg);
  wire ptr_in_b      = ptr_reg[PTR_BANK_BIT];
  wire [IDX_W-1:0] ptr_idx = ptr_reg[IDX_W-1:0];

  // ==========================================================
  // display memory banks, index 0 is bank A
  logic [DATA_W-1:0] sw_rd  [2];
  logic [DATA_W-1:0] pn_rd  [2];
  logic              bank_we [2];

  for (genvar b = 0; b < 2; b++) begin : g_bank
    // a reserved subaddress reaches neither bank
    assign bank_we[b] = WR && sel_portal && ptr_ok && (ptr_in_b == 1'(b));

    lcr_bank #(
      .DEPTH (BANK_BYTES),
      .WIDTH (DATA_W),
      .IDX_W (IDX_W)
    ) u_bank (
      .clk     (CLK),
      .resetn  (RESETN),
      .wr_en   (bank_we[b]),
      .wr_idx  (ptr_idx),
      .wr_data (WDATA),
      .sw_idx  (ptr_idx),
      .sw_data (sw_rd[b]),
      .pn_idx  (DISP_INDEX),
      .pn_data (pn_rd[b])
    );
  end

  wire [DATA_W-1:0] portal_data = ptr_ok ? sw_rd[ptr_in_b] : '0;

  // ==========================================================
  // pointer
  always_comb begin
    ptr_next = ptr_reg;
    if (WR && sel_ptr) begin
      // upper bits are not stored, software keeps them zero
      ptr_next = WDATA[SUBADDR_LSB +: PTR_W];
    end else if (portal_access) begin
      ptr_next = ptr_step(ptr_reg);
    end
  end

  // ==========================================================
  // control registers: software view and applied copy
  wire run_idle = (run_reg == LCR_IDLE);

  always_comb begin
    pend_next = pend_reg;
    if (WR && sel_clk) begin
      pend_next.clock_cfg = WDATA;
    end
    if (WR && sel_ctl0) begin
      pend_next.control_zero = WDATA;
    end
    if (WR && sel_ctl1) begin
      pend_next.control_one = WDATA;
    end
    if (WR && sel_ctl2) begin
      pend_next.control_two = WDATA;
    end
    if (WR && sel_ctl3) begin
      pend_next.control_three = WDATA;
    end
  end

  // a change mid-frame would leave dc on the glass, so it waits for
  // the frame boundary; with the panel stopped there is no frame to protect
  assign appl_next = (FRAME_END || run_idle) ? pend_reg : appl_reg;

  // ==========================================================
  // run control
  always_comb begin
    run_next = run_reg;
    case (run_reg)
      LCR_IDLE: begin
        if (POWER_ENABLE) begin
          run_next = LCR_RUN;
        end
      end
      LCR_RUN: begin
        // stop mode does not enter here: only the enable matters
        if (!POWER_ENABLE) begin
          run_next = LCR_DRAIN;
        end
      end
      LCR_DRAIN: begin
        if (POWER_ENABLE) begin
          run_next = LCR_RUN;
        end else if (FRAME_END) begin
          run_next = LCR_IDLE;
        end
      end
      default: begin
        run_next = LCR_IDLE;
      end
    endcase
  end

  // ==========================================================
  // interrupt event
  wire irq_on_blink = appl_reg.control_two[IRQ_SOURCE_BIT];
  wire [BLINK_MODE_W-1:0] blink_mode =
    appl_reg.control_zero[BLINK_MODE_LSB +: BLINK_MODE_W];
  wire [DMEM_MODE_W-1:0] dmem_mode =
    appl_reg.control_three[DMEM_MODE_LSB +: DMEM_MODE_W];

  wire ev_frame  = FRAME_END && !irq_on_blink;
  wire ev_blink  = BLINK_START && irq_on_blink &&
                   (blink_mode != BLINK_MODE_OFF);
  wire ev_switch = BANK_SWITCH_A_TO_B && (dmem_mode == DMEM_MODE_ALTERNATE);

  assign irq_next = !run_idle && (ev_frame || ev_blink || ev_switch);

  // ==========================================================
  // read data, valid only in the cycle after the strobe
  always_comb begin
    rdata_next = '0;
    if (RD) begin
      if (sel_ptr) begin
        rdata_next = {{(DATA_W-PTR_W){1'b0}}, ptr_reg};
      end else if (sel_portal) begin
        rdata_next = portal_data;
      end else if (sel_clk) begin
        rdata_next = pend_reg.clock_cfg;
      end else if (sel_ctl0) begin
        rdata_next = pend_reg.control_zero;
      end else if (sel_ctl1) begin
        rdata_next = pend_reg.control_one;
      end else if (sel_ctl2) begin
        rdata_next = pend_reg.control_two;
      end else if (sel_ctl3) begin
        rdata_next = pend_reg.control_three;
      end
    end
  end

  assign disp_next = pn_rd[DISP_BANK_B];

  // ==========================================================
  // flip-flops
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ptr_reg   <= RST_SUBADDRESS[PTR_W-1:0];
      pend_reg  <= {5{RST_CONTROL}};
      appl_reg  <= {5{RST_CONTROL}};
      run_reg   <= LCR_IDLE;
      rdata_reg <= '0;
      disp_reg  <= RST_MEMORY;
      irq_reg   <= 1'b0;
    end else begin
      ptr_reg   <= ptr_next;
      pend_reg  <= pend_next;
      appl_reg  <= appl_next;
      run_reg   <= run_next;
      rdata_reg <= rdata_next;
      disp_reg  <= disp_next;
      irq_reg   <= irq_next;
    end
  end

  // ==========================================================
  // outputs
  wire [CONTRAST_W-1:0] contrast_set =
    appl_reg.control_one[CONTRAST_LSB +: CONTRAST_W];

  assign CONTRAST.pump_level  = PUMP_SUPPLY ? contrast_set : '0;
  assign CONTRAST.dead_cycles = PUMP_SUPPLY ? '0 : contrast_set;
  assign RDATA       = rdata_reg;
  assign DISP_DATA   = disp_reg;
  assign RUNNING     = !run_idle;
  assign APPLIED_CFG = appl_reg;
  assign LCD_IRQ     = irq_reg;

endmodule : lcr_top

// file: shared/lcr_pkg.sv
// lcr_pkg: constants, field layout and types of the panel controller register bank
package lcr_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int PTR_W  = 5;
  localparam int IDX_W  = 4;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFF_SUBADDRESS_POINTER = 12'hfb1;
  localparam logic [ADDR_W-1:0] OFF_SUBDATA_PORTAL     = 12'hfb2;
  localparam logic [ADDR_W-1:0] OFF_PANEL_CLOCK_CONFIG = 12'hfb3;
  localparam logic [ADDR_W-1:0] OFF_PANEL_CONTROL_ZERO = 12'hfb4;
  localparam logic [ADDR_W-1:0] OFF_PANEL_CONTROL_ONE  = 12'hfb5;
  localparam logic [ADDR_W-1:0] OFF_PANEL_CONTROL_TWO  = 12'hfb6;
  localparam logic [ADDR_W-1:0] OFF_PANEL_CONTROL_THREE = 12'hfb7;

  // ==========================================================
  // reset values
  localparam logic [DATA_W-1:0] RST_SUBADDRESS = 8'h00;
  localparam logic [DATA_W-1:0] RST_CONTROL    = 8'h00;
  localparam logic [DATA_W-1:0] RST_MEMORY     = 8'h00;

  // ==========================================================
  // display memory subaddresses
  localparam int                BANK_DEPTH   = 12;
  localparam logic [PTR_W-1:0]  BANK_A_FIRST = 5'h00;
  localparam logic [PTR_W-1:0]  BANK_A_LAST  = 5'h0b;
  localparam logic [PTR_W-1:0]  BANK_B_FIRST = 5'h10;
  localparam logic [PTR_W-1:0]  BANK_B_LAST  = 5'h1b;
  localparam logic [IDX_W-1:0]  IDX_LAST     = 4'hb;
  localparam int                PTR_BANK_BIT = 4;

  // ==========================================================
  // field positions
  localparam int SUBADDR_LSB     = 0;
  localparam int IRQ_SOURCE_BIT  = 0;
  localparam int BLINK_MODE_LSB  = 1;
  localparam int BLINK_MODE_W    = 2;
  localparam int DMEM_MODE_LSB   = 0;
  localparam int DMEM_MODE_W     = 2;
  localparam int CONTRAST_LSB    = 0;
  localparam int CONTRAST_W      = 4;

  localparam logic [DMEM_MODE_W-1:0]  DMEM_MODE_ALTERNATE = 2'h2;
  localparam logic [BLINK_MODE_W-1:0] BLINK_MODE_OFF      = 2'h0;

  // ==========================================================
  // types
  typedef struct packed {
    logic [DATA_W-1:0] clock_cfg;
    logic [DATA_W-1:0] control_zero;
    logic [DATA_W-1:0] control_one;
    logic [DATA_W-1:0] control_two;
    logic [DATA_W-1:0] control_three;
  } lcr_ctrl_t;

  typedef struct packed {
    logic [CONTRAST_W-1:0] pump_level;
    logic [CONTRAST_W-1:0] dead_cycles;
  } lcr_contrast_t;

  typedef enum logic [1:0] {
    LCR_IDLE  = 2'b00,
    LCR_RUN   = 2'b01,
    LCR_DRAIN = 2'b10
  } lcr_run_t;

endpackage : lcr_pkg

// file: src/lcr_bank.sv
// lcr_bank: one display memory bank, one write port and two read ports
module lcr_bank #(
  parameter int DEPTH = 12,
  parameter int WIDTH = 8,
  parameter int IDX_W = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // write port
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  // software read port
  input  wire logic [IDX_W-1:0] sw_idx,
  output logic      [WIDTH-1:0] sw_data,
  // panel read port
  input  wire logic [IDX_W-1:0] pn_idx,
  output logic      [WIDTH-1:0] pn_data
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // ==========================================================
  // storage
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        mem_reg[i] <= '0;
      end else if (wr_en && (wr_idx == IDX_W'(i))) begin
        mem_reg[i] <= wr_data;
      end
    end
  end

  // an index beyond the bank reads as zero
  assign sw_data = (32'(sw_idx) < DEPTH) ? mem_reg[sw_idx] : '0;
  assign pn_data = (32'(pn_idx) < DEPTH) ? mem_reg[pn_idx] : '0;

endmodule : lcr_bank

// file: tb/lcr_monitor.sv
// lcr_monitor: port-level assertions for the panel controller register bank
module lcr_monitor
  import lcr_pkg::*;
#(
  parameter int BANK_BYTES = 12
) (
  // clock and reset
  input wire logic                   CLK,
  input wire logic                   RESETN,
  // register port
  input wire logic                   RD,
  input wire logic [lcr_pkg::DATA_W-1:0] RDATA,
  // power and events
  input wire logic                   POWER_ENABLE,
  input wire logic                   PUMP_SUPPLY,
  input wire logic                   FRAME_END,
  input wire logic                   BLINK_START,
  input wire logic                   BANK_SWITCH_A_TO_B,
  // state
  input wire logic                   RUNNING,
  input wire lcr_pkg::lcr_ctrl_t     APPLIED_CFG,
  input wire lcr_pkg::lcr_contrast_t CONTRAST,
  input wire logic                   LCD_IRQ
);
  timeunit 1ns;
  timeprecision 100ps;
  import lcr_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  wire src_blink = APPLIED_CFG.control_two[0];
  wire any_ev    = RUNNING && (FRAME_END || BLINK_START || BANK_SWITCH_A_TO_B);

  // =====================================================
  // read port and interrupt
  a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data not zero outside read cycle");
  a_irq_frame: assert property (RUNNING && FRAME_END && !src_blink |=> LCD_IRQ)
    else $error("frame end interrupt missing");
  a_irq_blink: assert property (RUNNING && BLINK_START && src_blink &&
    APPLIED_CFG.control_zero[2:1] != 2'h0 |=> LCD_IRQ) else $error("blink interrupt missing");
  a_irq_bank: assert property (RUNNING && BANK_SWITCH_A_TO_B &&
    APPLIED_CFG.control_three[1:0] == 2'h2 |=> LCD_IRQ) else $error("bank interrupt missing");
  a_irq_cause: assert property (LCD_IRQ |-> $past(any_ev))
    else $error("interrupt without event");
  a_irq_idle: assert property (!RUNNING |=> !LCD_IRQ)
    else $error("interrupt while controller stopped");

  // =====================================================
  // apply timing, run control and contrast outputs
  a_cfg_hold: assert property (RUNNING && !FRAME_END |=> $stable(APPLIED_CFG))
    else $error("config changed inside frame");
  a_run_start: assert property (POWER_ENABLE && !RUNNING |=> RUNNING)
    else $error("controller did not start");
  a_stop_late: assert property (RUNNING && !FRAME_END |=> RUNNING)
    else $error("controller stopped inside frame");
  a_pump_level: assert property (PUMP_SUPPLY |->
    CONTRAST.pump_level == APPLIED_CFG.control_one[3:0])
    else $error("pump level not from contrast");
  a_dead_cycles: assert property (!PUMP_SUPPLY |->
    CONTRAST.dead_cycles == APPLIED_CFG.control_one[3:0])
    else $error("dead cycles not from contrast");
endmodule : lcr_monitor

bind lcr_top lcr_monitor #(.BANK_BYTES(BANK_BYTES)) u_mon (
  .CLK(CLK), .RESETN(RESETN), .RD(RD), .RDATA(RDATA), .POWER_ENABLE(POWER_ENABLE),
  .PUMP_SUPPLY(PUMP_SUPPLY), .FRAME_END(FRAME_END), .BLINK_START(BLINK_START),
  .BANK_SWITCH_A_TO_B(BANK_SWITCH_A_TO_B), .RUNNING(RUNNING),
  .APPLIED_CFG(APPLIED_CFG), .CONTRAST(CONTRAST), .LCD_IRQ(LCD_IRQ));

// file: tb/lcr_panel.sv
// lcr_panel: frame timing source and display memory reader on the panel side
module lcr_panel (
  // clock
  input  wire logic       clk,
  // frame events
  output logic            frame_end,
  output logic            blink_start,
  output logic            bank_switch,
  // display memory read
  output logic            disp_bank_b,
  output logic [3:0]      disp_index,
  input  wire logic [7:0] disp_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {bank_switch, blink_start, frame_end} = 3'h0;
    disp_bank_b = 1'b0;
    disp_index  = 4'h0;
  end

  // one-cycle event pulse, bits {bank switch, blink, frame end}
  task pulse(input logic [2:0] ev);
    @(posedge clk);
    {bank_switch, blink_start, frame_end} <= ev;
    @(posedge clk);
    {bank_switch, blink_start, frame_end} <= 3'h0;
  endtask : pulse

  // data is registered, so it is taken one edge after the index
  task look(input logic b, input logic [3:0] idx, output logic [7:0] d);
    @(posedge clk);
    disp_bank_b <= b;
    disp_index  <= idx;
    @(posedge clk);
    #1 d = disp_data;
  endtask : look
endmodule : lcr_panel

// file: tb/tb.sv
// tb: self-checking bench for the panel controller register bank
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import lcr_pkg::*;
  logic CLK, RESETN, WR, RD, POWER_ENABLE, PUMP_SUPPLY;
  logic [11:0] ADDR;
  logic [7:0]  WDATA, RDATA, DISP_DATA, d;
  logic        FRAME_END, BLINK_START, BANK_SWITCH_A_TO_B, DISP_BANK_B, RUNNING, LCD_IRQ;
  logic [3:0]  DISP_INDEX;
  lcr_ctrl_t     APPLIED_CFG;
  lcr_contrast_t CONTRAST;
  int err_total = 0, n_tests = 0;

  lcr_top #(.BANK_BYTES(12)) i_lcr_top (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .POWER_ENABLE(POWER_ENABLE),
    .PUMP_SUPPLY(PUMP_SUPPLY), .FRAME_END(FRAME_END), .BLINK_START(BLINK_START),
    .BANK_SWITCH_A_TO_B(BANK_SWITCH_A_TO_B), .DISP_BANK_B(DISP_BANK_B),
    .DISP_INDEX(DISP_INDEX), .DISP_DATA(DISP_DATA), .RUNNING(RUNNING),
    .APPLIED_CFG(APPLIED_CFG), .CONTRAST(CONTRAST), .LCD_IRQ(LCD_IRQ));
  lcr_panel u_panel (.clk(CLK), .frame_end(FRAME_END), .blink_start(BLINK_START),
    .bank_switch(BANK_SWITCH_A_TO_B), .disp_bank_b(DISP_BANK_B),
    .disp_index(DISP_INDEX), .disp_data(DISP_DATA));

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  // =====================================================
  // bus, compare and verdict
  task chk(input logic [39:0] g, input logic [39:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge CLK);
    ADDR <= a; WDATA <= v; WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a; RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(RDATA, e);
  endtask : rd
  task results;
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  // =====================================================
  // scenarios
  task t_reset;
    for (int i = 1; i < 8; i++) rd(12'hfb0 + i[11:0], 8'h00);
    wr(12'hfb8, 8'hff);
    rd(12'hfb8, 8'h00);
    rd(12'hfb0, 8'h00);
  endtask : t_reset
  task t_bank_a;
    wr(12'hfb1, 8'h00);
    for (int i = 0; i < 12; i++) wr(12'hfb2, 8'ha0 + i[7:0]);
    rd(12'hfb1, 8'h00);
    for (int i = 0; i < 12; i++) begin
      rd(12'hfb2, 8'ha0 + i[7:0]);
      u_panel.look(1'b0, i[3:0], d);
      chk(d, 8'ha0 + i[7:0]);
    end
  endtask : t_bank_a
  task t_bank_b;
    wr(12'hfb1, 8'h1b);
    wr(12'hfb2, 8'h5c);
    rd(12'hfb1, 8'h10);
    wr(12'hfb2, 8'h51);
    rd(12'hfb1, 8'h11);
    u_panel.look(1'b1, 4'hb, d);
    chk(d, 8'h5c);
    u_panel.look(1'b1, 4'h0, d);
    chk(d, 8'h51);
  endtask : t_bank_b
  task t_reserved;
    wr(12'hfb1, 8'h0c);
    wr(12'hfb2, 8'hee);
    rd(12'hfb1, 8'h0d);
    wr(12'hfb1, 8'h0c);
    rd(12'hfb2, 8'h00);
    wr(12'hfb1, 8'h1c);
    wr(12'hfb2, 8'hee);
    u_panel.look(1'b0, 4'h0, d);
    chk(d, 8'ha0);
    u_panel.look(1'b1, 4'h0, d);
    chk(d, 8'h51);
  endtask : t_reserved
  task t_apply;
    @(posedge CLK);
    POWER_ENABLE <= 1'b1;
    PUMP_SUPPLY  <= 1'b1;
    @(posedge CLK);
    @(posedge CLK);
    #1 chk(RUNNING, 1'b1);
    wr(12'hfb5, 8'h07);
    rd(12'hfb5, 8'h07);
    chk(APPLIED_CFG.control_one, 8'h00);
    u_panel.pulse(3'b001);
    #1 chk(APPLIED_CFG.control_one, 8'h07);
    chk(LCD_IRQ, 1'b1);
    chk(CONTRAST.pump_level, 4'h7);
    @(posedge CLK);
    PUMP_SUPPLY <= 1'b0;
    #1 chk(CONTRAST.dead_cycles, 4'h7);
  endtask : t_apply
  task t_irq;
    wr(12'hfb6, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wr(12'hfb4, 8'(m << 1));
      u_panel.pulse(3'b001);
      #1 chk(LCD_IRQ, m == 0);
      u_panel.pulse(3'b010);
      #1 chk(LCD_IRQ, m != 0);
    end
    for (int k = 1; k < 3; k++) begin
      wr(12'hfb7, k[7:0]);
      u_panel.pulse(3'b001);
      u_panel.pulse(3'b100);
      #1 chk(LCD_IRQ, k == 2);
    end
  endtask : t_irq
  task t_stop;
    @(posedge CLK);
    POWER_ENABLE <= 1'b0;
    repeat (3) @(posedge CLK);
    #1 chk(RUNNING, 1'b1);
    u_panel.pulse(3'b001);
    #1 chk(RUNNING, 1'b0);
    wr(12'hfb5, 8'h03);
    @(posedge CLK);
    @(posedge CLK);
    #1 chk(APPLIED_CFG.control_one, 8'h03);
  endtask : t_stop

  // =====================================================
  // main sequence and hang guard
  initial begin
    // every driven input starts at its idle level, reset asserted
    {RESETN, WR, RD} = 3'h0;
    {POWER_ENABLE, PUMP_SUPPLY} = 2'h0;
    ADDR = 12'h000;
    WDATA = 8'h00;
    repeat (4) @(posedge CLK);
    RESETN <= 1'b1;
    t_reset();
    t_bank_a();
    t_bank_b();
    t_reserved();
    t_apply();
    t_irq();
    t_stop();
    results();
  end
  initial begin
    repeat (20000) @(posedge CLK);
    err_total++;
    results();
  end
endmodule : tb
